// file: verif/jtag_master_model.sv
// JTAG master model: drives the test pins through standard TAP sequences
`timescale 1ns/1ps
module jtag_master_model
    import tap_decode_pkg::*;
(
    // Clock
    input  wire logic i_mclk,
    // Test access pins
    input  wire logic i_tdo,
    output logic      o_tck,
    output logic      o_tms,
    output logic      o_tdi
);
    // Test clock stands low between frames
    initial begin
        o_tck = 1'h0;
        o_tms = 1'h1;
        o_tdi = 1'h0;
    end

    // One test clock, 160 ns; tdo read at end of high phase, where it has settled
    task automatic clock_bit(input logic tms_v, input logic tdi_v, output logic tdo_v);
        o_tms <= tms_v;
        o_tdi <= tdi_v;
        repeat (4) @(posedge i_mclk);
        o_tck <= 1'h1;
        repeat (4) @(posedge i_mclk);
        tdo_v = i_tdo;
        o_tck <= 1'h0;
    endtask

    // Test-Logic-Reset, then Run-Test/Idle
    task automatic goto_idle();
        logic t;
        repeat (5) clock_bit(1'h1, 1'h0, t);
        clock_bit(1'h0, 1'h0, t);
    endtask

    // Idle to Exit1-IR, opcode LSB first
    task automatic ir_shift(input logic [5:0] op, output logic [5:0] cap);
        logic t;
        if (op == OP_FACT_TEST || op == OP_FACT_DEBUG) begin
            op = OP_BYPASS;
        end
        clock_bit(1'h1, 1'h0, t);
        clock_bit(1'h1, 1'h0, t);
        clock_bit(1'h0, 1'h0, t);
        clock_bit(1'h0, 1'h0, t);
        for (int i = 0; i < 6; i++) begin
            clock_bit(i == 5, op[i], cap[i]);
        end
    endtask

    // Idle to Exit1-DR, n bits LSB first
    task automatic dr_shift(input int n, input logic [31:0] din, output logic [31:0] dout);
        logic t;
        dout = '0;
        clock_bit(1'h1, 1'h0, t);
        clock_bit(1'h0, 1'h0, t);
        clock_bit(1'h0, 1'h0, t);
        for (int i = 0; i < n; i++) begin
            clock_bit(i == n - 1, din[i], dout[i]);
        end
    endtask

    // Exit1 through Update back to Idle
    task automatic leave();
        logic t;
        clock_bit(1'h1, 1'h0, t);
        clock_bit(1'h0, 1'h0, t);
    endtask
endmodule

// file: verif/tap_instruction_decoder_tb.sv
// Self-checking bench for the TAP instruction decoder
`timescale 1ns/1ps
module tap_instruction_decoder_tb
    import tap_decode_pkg::*;
;
    // Arbitrary identification value
    localparam logic [31:0] TB_ID = 32'hC0DE_5A01;

    logic                 mclk;
    logic                 rst;
    logic                 tck;
    logic                 tms;
    logic                 tdi;
    logic                 tdo;
    logic                 tdo_oe_n;
    logic                 dbg_tdo;
    logic                 pin_tdo;
    logic [AUX_COUNT-1:0] aux_tdo;
    decode_t              decode;
    decode_t              e;
    logic                 tdo_line;
    logic                 cap_dr;
    logic                 shift_dr;
    logic                 upd_dr;
    int                   n_cap = 0;
    int                   n_shift = 0;
    int                   n_upd = 0;
    // Data scans so far, the identification scan included
    int                   scans = 1;
    logic [5:0]           opcode;
    logic [5:0]           op;
    logic [5:0]           cap;
    logic [31:0]          dout;
    logic [7:0]           lfsr_reg = 8'h52;
    int                   bad_count = 0;
    int                   tests_run = 0;

    tap_instruction_decoder #(.ID_VALUE(TB_ID)) DUT (
        .i_mclk(mclk), .i_rst(rst), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
        .o_tdo(tdo), .o_tdo_oe_n(tdo_oe_n), .i_dbg_ctrl_tdo(dbg_tdo),
        .i_dbg_pinctrl_tdo(pin_tdo), .i_aux_tdo(aux_tdo), .o_decode(decode),
        .o_opcode(opcode), .o_capture_dr(cap_dr), .o_shift_dr(shift_dr), .o_update_dr(upd_dr)
    );

    jtag_master_model u_master (
        .i_mclk(mclk), .i_tdo(tdo_line), .o_tck(tck), .o_tms(tms), .o_tdi(tdi)
    );

    // Released data out reads inverted, so a late enable shows as bad data
    assign tdo_line = tdo_oe_n ? ~tdo : tdo;

    always @(posedge mclk) begin
        if (cap_dr === 1'h1) n_cap <= n_cap + 1;
        if (shift_dr === 1'h1) n_shift <= n_shift + 1;
        if (upd_dr === 1'h1) n_upd <= n_upd + 1;
    end

    function automatic logic [7:0] lfsr_step(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    function automatic decode_t exp_dec(input logic [5:0] c);
        decode_t d;
        d = '0;
        case (c)
            OP_IDCODE:       d.sel_idcode = 1'h1;
            OP_CLAMP:        d = '{sel_bypass: 1'h1, pins_clamp: 1'h1, func_reset: 1'h1, default: '0};
            OP_HIGHZ:        d = '{sel_bypass: 1'h1, pins_highz: 1'h1, func_reset: 1'h1, default: '0};
            OP_DBG_CTRL:     d.sel_dbg_ctrl = 1'h1;
            OP_DBG_PINCTRL:  d.sel_dbg_pinctrl = 1'h1;
            OP_AUX_TRACE:    d.aux_grant[AUX_TRACE] = 1'h1;
            OP_AUX_CHALRESP: d.aux_grant[AUX_CHALRESP] = 1'h1;
            OP_AUX_SECCORE:  d.aux_grant[AUX_SECCORE] = 1'h1;
            OP_AUX_CORE0:    d.aux_grant[AUX_CORE0] = 1'h1;
            OP_AUX_CORE1:    d.aux_grant[AUX_CORE1] = 1'h1;
            OP_AUX_CORE2:    d.aux_grant[AUX_CORE2] = 1'h1;
            OP_AUX_TIMER:    d.aux_grant[AUX_TIMER] = 1'h1;
            OP_AUX_BUSMON0:  d.aux_grant[AUX_BUSMON0] = 1'h1;
            OP_AUX_BUSMON1:  d.aux_grant[AUX_BUSMON1] = 1'h1;
            OP_AUX_SEQUNIT:  d.aux_grant[AUX_SEQUNIT] = 1'h1;
            OP_AUX_PARALLEL: d.aux_grant[AUX_ALLCORES] = 1'h1;
            default:         d.sel_bypass = 1'h1;
        endcase
        return d;
    endfunction

    // Serial data seen on tdo for an eight-bit data scan
    function automatic logic [7:0] exp_dr(input decode_t d, input logic [7:0] din);
        for (int k = 0; k < AUX_COUNT; k++) begin
            if (d.aux_grant[k]) begin
                return {8{aux_tdo[k]}};
            end
        end
        if (d.sel_idcode) return TB_ID[7:0];
        if (d.sel_dbg_ctrl) return {8{dbg_tdo}};
        if (d.sel_dbg_pinctrl) return {8{pin_tdo}};
        return {din[6:0], 1'h0};
    endfunction

    task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
        tests_run++;
        if (g !== x) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, x, g);
        end
    endtask

    task automatic test_done();
        if (bad_count == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'h0;
        forever #10 mclk = ~mclk;
    end

    initial begin
        repeat (90000) @(posedge mclk);
        bad_count++;
        test_done();
    end

    initial begin
        rst = 1'h1;
        dbg_tdo = 1'h0;
        pin_tdo = 1'h1;
        aux_tdo = '0;
        repeat (3) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        chk("opcode", 32'(OP_IDCODE), 32'(opcode));
        chk("tdo_oe_n", 32'h1, 32'(tdo_oe_n));
        u_master.goto_idle();
        u_master.dr_shift(32, 32'h0, dout);
        chk("idcode", TB_ID, dout);
        u_master.leave();
        chk("opcode", 32'(OP_IDCODE), 32'(opcode));
        chk("capture pulses", 32'h1, 32'(n_cap));
        chk("shift pulses", 32'h20, 32'(n_shift));
        chk("update pulses", 32'h1, 32'(n_upd));
        u_master.ir_shift(OP_DBG_CTRL, cap);
        chk("ir capture", 32'h01, 32'(cap));
        chk("opcode", 32'(OP_IDCODE), 32'(opcode));
        u_master.leave();
        chk("opcode", 32'(OP_DBG_CTRL), 32'(opcode));
        // Every opcode but the two factory codes once, in a scrambled order
        for (int i = 0; i < 64; i++) begin
            op = 6'(i * 37 + 11);
            lfsr_reg = lfsr_step(lfsr_reg);
            if (op == OP_FACT_TEST || op == OP_FACT_DEBUG) continue;
            aux_tdo <= {lfsr_reg[2:0], ~lfsr_reg};
            dbg_tdo <= lfsr_reg[0];
            pin_tdo <= ~lfsr_reg[0];
            u_master.ir_shift(op, cap);
            u_master.leave();
            e = exp_dec(op);
            chk("opcode", 32'(op), 32'(opcode));
            chk("decode", 32'(e), 32'(decode));
            // For the parallel opcode this scan stands for the synchronous exit command
            u_master.dr_shift(8, 32'(lfsr_reg), dout);
            u_master.leave();
            chk("data path", 32'(exp_dr(e, lfsr_reg)), dout);
            scans++;
        end
        chk("capture pulses", 32'(scans), 32'(n_cap));
        chk("shift pulses", 32'(24 + 8 * scans), 32'(n_shift));
        chk("update pulses", 32'(scans), 32'(n_upd));
        u_master.ir_shift(OP_BYPASS, cap);
        u_master.leave();
        u_master.goto_idle();
        chk("opcode", 32'(OP_IDCODE), 32'(opcode));
        u_master.ir_shift(OP_CLAMP, cap);
        u_master.leave();
        chk("opcode", 32'(OP_CLAMP), 32'(opcode));
        rst <= 1'h1;
        repeat (2) @(posedge mclk);
        rst <= 1'h0;
        repeat (4) @(posedge mclk);
        chk("opcode", 32'(OP_IDCODE), 32'(opcode));
        chk("decode", 32'(exp_dec(OP_IDCODE)), 32'(decode));
        test_done();
    end
endmodule

// file: verilog/tap_decode_pkg.sv
// Package: opcodes, timing, carrier structs for the TAP instruction decoder
package tap_decode_pkg;
    localparam int          IR_WIDTH          = 6;
    localparam int          ID_WIDTH          = 32;
    localparam int          SYNC_STAGES       = 2;
    localparam logic [5:0]  OP_IDCODE         = 6'h01;
    localparam logic [5:0]  OP_HIGHZ          = 6'h09;
    localparam logic [5:0]  OP_FACT_DEBUG     = 6'h0A;
    localparam logic [5:0]  OP_CLAMP          = 6'h0C;
    localparam logic [5:0]  OP_DBG_CTRL       = 6'h0E;
    localparam logic [5:0]  OP_DBG_PINCTRL    = 6'h0F;
    localparam logic [5:0]  OP_AUX_LO         = 6'h20;
    localparam logic [5:0]  OP_AUX_HI         = 6'h3E;
    localparam logic [5:0]  OP_AUX_TRACE      = 6'h21;
    localparam logic [5:0]  OP_FACT_TEST      = 6'h25;
    localparam logic [5:0]  OP_AUX_CHALRESP   = 6'h26;
    localparam logic [5:0]  OP_AUX_SECCORE    = 6'h27;
    localparam logic [5:0]  OP_AUX_CORE0      = 6'h28;
    localparam logic [5:0]  OP_AUX_CORE1      = 6'h29;
    localparam logic [5:0]  OP_AUX_CORE2      = 6'h2A;
    localparam logic [5:0]  OP_AUX_TIMER      = 6'h33;
    localparam logic [5:0]  OP_AUX_BUSMON0    = 6'h34;
    localparam logic [5:0]  OP_AUX_BUSMON1    = 6'h35;
    localparam logic [5:0]  OP_AUX_SEQUNIT    = 6'h3A;
    localparam logic [5:0]  OP_AUX_PARALLEL   = 6'h3F - 6'h03;
    localparam logic [5:0]  OP_BYPASS         = 6'h3F;
    // Neutral identification value, arbitrary
    localparam logic [31:0] ID_VALUE_DEFAULT  = 32'h1234_5001;

    // Auxiliary owners, one bit each
    localparam int          AUX_COUNT         = 11;
    localparam int          AUX_TRACE         = 0;
    localparam int          AUX_CHALRESP      = 1;
    localparam int          AUX_SECCORE       = 2;
    localparam int          AUX_CORE0         = 3;
    localparam int          AUX_CORE1         = 4;
    localparam int          AUX_CORE2         = 5;
    localparam int          AUX_TIMER         = 6;
    localparam int          AUX_BUSMON0       = 7;
    localparam int          AUX_BUSMON1       = 8;
    localparam int          AUX_SEQUNIT       = 9;
    localparam int          AUX_ALLCORES      = 10;

    typedef enum logic [15:0] {
        TS_RESET      = 16'h0001,
        TS_IDLE       = 16'h0002,
        TS_SEL_DR     = 16'h0004,
        TS_CAP_DR     = 16'h0008,
        TS_SHIFT_DR   = 16'h0010,
        TS_EXIT1_DR   = 16'h0020,
        TS_PAUSE_DR   = 16'h0040,
        TS_EXIT2_DR   = 16'h0080,
        TS_UPD_DR     = 16'h0100,
        TS_SEL_IR     = 16'h0200,
        TS_CAP_IR     = 16'h0400,
        TS_SHIFT_IR   = 16'h0800,
        TS_EXIT1_IR   = 16'h1000,
        TS_PAUSE_IR   = 16'h2000,
        TS_EXIT2_IR   = 16'h4000,
        TS_UPD_IR     = 16'h8000
    } tap_state_t;

    // Decoded path selection
    typedef struct packed {
        logic                 sel_bypass;
        logic                 sel_idcode;
        logic                 sel_dbg_ctrl;
        logic                 sel_dbg_pinctrl;
        logic                 pins_clamp;
        logic                 pins_highz;
        logic                 func_reset;
        logic [AUX_COUNT-1:0] aux_grant;
    } decode_t;

    // Synchronised test pins
    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } tap_pins_t;
endpackage

// file: verilog/tap_instruction_decoder.sv
// TAP controller with instruction decode and path selection
// Summary of operation
// R1 - Instruction register holds a six-bit opcode choosing the data path.
// R2 - Clamp opcode: bypass path, preloaded values on pins, functional reset held.
// R3 - High-impedance opcode: bypass path, all outputs floated, functional reset held.
// R4 - Debug-interface control opcode selects that control register for scanning.
// R5 - Debug-interface pin-control opcode selects that register for scanning.
// R6 - Upper opcode half is the auxiliary group; defined codes hand over ownership.
// R7 - Trace opcode grants ownership to the power-domain trace controller.
// R8 - Challenge-response opcode grants ownership to the security challenge controller.
// R9 - Security-core opcode grants ownership to the security module core controller.
// R10 - Three core opcodes grant ownership to core 0, 1 and 2 debug.
// R11 - Timer opcode grants ownership to the timer module controller.
// R12 - Two bus-monitor opcodes grant ownership to monitor clients 0 and 1.
// R13 - Sequence-unit opcode grants ownership to the sequence unit controller.
// R14 - Parallel opcode grants access to all core debug controllers at once.
// R15 - Master uses parallel access only for the synchronous debug exit command.
// R16 - Master never loads factory test or factory debug opcodes.
// R17 - Bypass opcode places the one-bit bypass register between data in and out.
// R18 - Every undefined or reserved opcode decodes to the bypass register.
// R19 - Controller reset loads the identification instruction.
// R20 - Identification: capture 32-bit value, shift out LSB first, no update action.
// R21 - Standard TAP state sequence; new opcode takes effect at Update-IR.
`timescale 1ns/1ps
module tap_instruction_decoder
    import tap_decode_pkg::*;
#(
    parameter logic [ID_WIDTH-1:0] ID_VALUE = ID_VALUE_DEFAULT
) (
    // Clock and reset
    input  wire logic                 i_mclk,
    input  wire logic                 i_rst,
    // Test access pins
    input  wire logic                 i_tck,
    input  wire logic                 i_tms,
    input  wire logic                 i_tdi,
    output logic                      o_tdo,
    output logic                      o_tdo_oe_n,
    // Scanned registers outside the block
    input  wire logic                 i_dbg_ctrl_tdo,
    input  wire logic                 i_dbg_pinctrl_tdo,
    input  wire logic [AUX_COUNT-1:0] i_aux_tdo,
    // Decoded selection and TAP events
    output decode_t                   o_decode,
    output logic [IR_WIDTH-1:0]       o_opcode,
    output logic                      o_capture_dr,
    output logic                      o_shift_dr,
    output logic                      o_update_dr
);
    function automatic decode_t decode_op(input logic [IR_WIDTH-1:0] op);
        decode_t d;
        d = '0;
        case (op)
            OP_IDCODE:       d.sel_idcode = 1'b1;
            OP_CLAMP: begin                                   // R2
                d.sel_bypass = 1'b1;
                d.pins_clamp = 1'b1;
                d.func_reset = 1'b1;
            end
            OP_HIGHZ: begin                                   // R3
                d.sel_bypass = 1'b1;
                d.pins_highz = 1'b1;
                d.func_reset = 1'b1;
            end
            OP_DBG_CTRL:     d.sel_dbg_ctrl = 1'b1;             // R4
            OP_DBG_PINCTRL:  d.sel_dbg_pinctrl = 1'b1;          // R5
            OP_AUX_TRACE:    d.aux_grant[AUX_TRACE] = 1'b1;     // R7
            OP_AUX_CHALRESP: d.aux_grant[AUX_CHALRESP] = 1'b1;  // R8
            OP_AUX_SECCORE:  d.aux_grant[AUX_SECCORE] = 1'b1;   // R9
            OP_AUX_CORE0:    d.aux_grant[AUX_CORE0] = 1'b1;     // R10
            OP_AUX_CORE1:    d.aux_grant[AUX_CORE1] = 1'b1;     // R10
            OP_AUX_CORE2:    d.aux_grant[AUX_CORE2] = 1'b1;     // R10
            OP_AUX_TIMER:    d.aux_grant[AUX_TIMER] = 1'b1;     // R11
            OP_AUX_BUSMON0:  d.aux_grant[AUX_BUSMON0] = 1'b1;   // R12
            OP_AUX_BUSMON1:  d.aux_grant[AUX_BUSMON1] = 1'b1;   // R12
            OP_AUX_SEQUNIT:  d.aux_grant[AUX_SEQUNIT] = 1'b1;   // R13
            OP_AUX_PARALLEL: d.aux_grant[AUX_ALLCORES] = 1'b1;  // R14
            // Reserved aux codes, factory codes and the rest fall to bypass
            default:         d.sel_bypass = 1'b1;               // R6 R17 R18
        endcase
        return d;
    endfunction

    typedef struct packed {
        tap_state_t            tap;
        logic                  tck_prev;
        logic [IR_WIDTH-1:0]   ir_shift;
        logic [IR_WIDTH-1:0]   ir;
        logic [ID_WIDTH-1:0]   dr_shift;
        logic                  bypass;
        logic                  tdo;
        logic                  tdo_oe_n;
    } core_state_t;

    tap_pins_t   pins_raw;
    tap_pins_t   pins_sync;
    core_state_t state_reg;
    core_state_t state_next;
    logic        tck_rise;
    logic        tck_fall;
    decode_t     dec;

    assign pins_raw = '{tck: i_tck, tms: i_tms, tdi: i_tdi};

    tap_pin_sync u_sync (
        .i_mclk (i_mclk),
        .i_rst  (i_rst),
        .i_pins (pins_raw),
        .o_pins (pins_sync)
    );

    // Edges found on the synchronised test clock only
    assign tck_rise = pins_sync.tck & ~state_reg.tck_prev;
    assign tck_fall = ~pins_sync.tck & state_reg.tck_prev;
    assign dec      = decode_op(state_reg.ir);                 // R1

    function automatic tap_state_t next_tap(input tap_state_t s, input logic tms);
        case (s)
            TS_RESET:    next_tap = tms ? TS_RESET   : TS_IDLE;
            TS_IDLE:     next_tap = tms ? TS_SEL_DR  : TS_IDLE;
            TS_SEL_DR:   next_tap = tms ? TS_SEL_IR  : TS_CAP_DR;
            TS_CAP_DR:   next_tap = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_SHIFT_DR: next_tap = tms ? TS_EXIT1_DR : TS_SHIFT_DR;
            TS_EXIT1_DR: next_tap = tms ? TS_UPD_DR  : TS_PAUSE_DR;
            TS_PAUSE_DR: next_tap = tms ? TS_EXIT2_DR : TS_PAUSE_DR;
            TS_EXIT2_DR: next_tap = tms ? TS_UPD_DR  : TS_SHIFT_DR;
            TS_UPD_DR:   next_tap = tms ? TS_SEL_DR  : TS_IDLE;
            TS_SEL_IR:   next_tap = tms ? TS_RESET   : TS_CAP_IR;
            TS_CAP_IR:   next_tap = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_SHIFT_IR: next_tap = tms ? TS_EXIT1_IR : TS_SHIFT_IR;
            TS_EXIT1_IR: next_tap = tms ? TS_UPD_IR  : TS_PAUSE_IR;
            TS_PAUSE_IR: next_tap = tms ? TS_EXIT2_IR : TS_PAUSE_IR;
            TS_EXIT2_IR: next_tap = tms ? TS_UPD_IR  : TS_SHIFT_IR;
            TS_UPD_IR:   next_tap = tms ? TS_SEL_DR  : TS_IDLE;
            default:     next_tap = TS_RESET;
        endcase
    endfunction

    always_comb begin
        logic sel_tdo;
        sel_tdo    = 1'b0;
        state_next = state_reg;
        state_next.tck_prev = pins_sync.tck;
        // Data-out mux chosen by the active instruction
        if (dec.sel_idcode) begin
            sel_tdo = state_reg.dr_shift[0];                    // R20
        end else if (dec.sel_dbg_ctrl) begin
            sel_tdo = i_dbg_ctrl_tdo;
        end else if (dec.sel_dbg_pinctrl) begin
            sel_tdo = i_dbg_pinctrl_tdo;
        end else if (|dec.aux_grant) begin
            sel_tdo = |(dec.aux_grant & i_aux_tdo);
        end else begin
            sel_tdo = state_reg.bypass;                         // R17
        end
        if (tck_rise) begin
            state_next.tap = next_tap(state_reg.tap, pins_sync.tms); // R21
            case (state_reg.tap)
                TS_RESET: begin
                    state_next.ir = OP_IDCODE;                  // R19
                end
                TS_CAP_DR: begin
                    state_next.dr_shift = ID_VALUE;             // R20
                    state_next.bypass   = 1'b0;
                end
                TS_SHIFT_DR: begin
                    state_next.dr_shift = {pins_sync.tdi, state_reg.dr_shift[ID_WIDTH-1:1]}; // R20
                    state_next.bypass   = pins_sync.tdi;
                end
                TS_CAP_IR: begin
                    state_next.ir_shift = {{(IR_WIDTH-1){1'b0}}, 1'b1};
                end
                TS_SHIFT_IR: begin
                    state_next.ir_shift = {pins_sync.tdi, state_reg.ir_shift[IR_WIDTH-1:1]};
                end
                TS_UPD_IR: begin
                    state_next.ir = state_reg.ir_shift;         // R21
                end
                default: begin
                end
            endcase
        end
        // Data out changes on the falling test clock
        if (tck_fall) begin
            case (state_reg.tap)
                TS_SHIFT_DR: begin
                    state_next.tdo      = sel_tdo;
                    state_next.tdo_oe_n = 1'b0;
                end
                TS_SHIFT_IR: begin
                    state_next.tdo      = state_reg.ir_shift[0];
                    state_next.tdo_oe_n = 1'b0;
                end
                default: begin
                    state_next.tdo_oe_n = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg          <= '0;
            state_reg.tap      <= TS_RESET;
            state_reg.ir       <= OP_IDCODE;                    // R19
            state_reg.tdo_oe_n <= 1'b1;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_tdo        = state_reg.tdo;
    assign o_tdo_oe_n   = state_reg.tdo_oe_n;
    assign o_decode     = dec;
    assign o_opcode     = state_reg.ir;
    assign o_capture_dr = tck_rise && (state_reg.tap == TS_CAP_DR);
    assign o_shift_dr   = tck_rise && (state_reg.tap == TS_SHIFT_DR);
    assign o_update_dr  = tck_rise && (state_reg.tap == TS_UPD_DR);

    // Assertions
    a_clamp_decode: assert property (@(posedge i_mclk) disable iff (i_rst) // R2
        state_reg.ir == OP_CLAMP |-> o_decode.sel_bypass && o_decode.pins_clamp && o_decode.func_reset)
        else $error("clamp decode wrong");
    a_highz_decode: assert property (@(posedge i_mclk) disable iff (i_rst) // R3
        state_reg.ir == OP_HIGHZ |-> o_decode.sel_bypass && o_decode.pins_highz && o_decode.func_reset)
        else $error("highz decode wrong");
    a_dbg_ctrl_sel: assert property (@(posedge i_mclk) disable iff (i_rst) // R4
        o_decode.sel_dbg_ctrl == (state_reg.ir == OP_DBG_CTRL))
        else $error("debug control select wrong");
    a_pinctrl_sel: assert property (@(posedge i_mclk) disable iff (i_rst) // R5
        o_decode.sel_dbg_pinctrl == (state_reg.ir == OP_DBG_PINCTRL))
        else $error("pin control select wrong");
    a_aux_onehot: assert property (@(posedge i_mclk) disable iff (i_rst) // R6
        $onehot0(o_decode.aux_grant) && (!(|o_decode.aux_grant) || (state_reg.ir >= OP_AUX_LO)))
        else $error("aux grant not one-hot or out of group");
    a_core_grant: assert property (@(posedge i_mclk) disable iff (i_rst) // R10
        state_reg.ir == OP_AUX_CORE1 |-> o_decode.aux_grant[AUX_CORE1])
        else $error("core 1 grant missing");
    a_bypass_default: assert property (@(posedge i_mclk) disable iff (i_rst) // R18
        (state_reg.ir == OP_FACT_TEST || state_reg.ir == OP_BYPASS) |-> o_decode.sel_bypass)
        else $error("bypass default missing");
    sequence s_reset_entry;
        tck_rise && state_reg.tap == TS_RESET;
    endsequence
    a_reset_idcode: assert property (@(posedge i_mclk) disable iff (i_rst) // R19
        s_reset_entry |=> state_reg.ir == OP_IDCODE)
        else $error("reset did not load identification");
    sequence s_capture_id;
        tck_rise && state_reg.tap == TS_CAP_DR;
    endsequence
    a_id_capture: assert property (@(posedge i_mclk) disable iff (i_rst) // R20
        s_capture_id |=> state_reg.dr_shift == ID_VALUE)
        else $error("identification not captured");
    a_ir_update_only: assert property (@(posedge i_mclk) disable iff (i_rst) // R21
        state_reg.ir != $past(state_reg.ir) |-> $past(state_reg.tap) inside {TS_UPD_IR, TS_RESET})
        else $error("opcode changed outside update");
endmodule

// file: verilog/tap_pin_sync.sv
// Two-flop synchroniser for the test pins
`timescale 1ns/1ps
module tap_pin_sync
    import tap_decode_pkg::*;
(
    // Clock and reset
    input  wire logic      i_mclk,
    input  wire logic      i_rst,
    // Raw and synchronised pins
    input  wire tap_pins_t i_pins,
    output tap_pins_t      o_pins
);
    typedef struct packed {
        tap_pins_t stage1;
        tap_pins_t stage2;
    } sync_state_t;

    sync_state_t state_reg;
    sync_state_t state_next;

    always_comb begin
        state_next        = state_reg;
        state_next.stage1 = i_pins;
        state_next.stage2 = state_reg.stage1;
    end

    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign o_pins = state_reg.stage2;
endmodule
